// ### design/qpac_consts.vh
// Shared constants for the quad pipeline converter core control
`ifndef QPAC_CONSTS_VH
`define QPAC_CONSTS_VH
`define QPAC_CHANNELS 4
`define QPAC_WORD_BITS 8
`define QPAC_STAGES 6
`define QPAC_FLASH_BITS 3
`define QPAC_LATENCY 6
`define QPAC_CLK_MHZ 40
`define QPAC_DLL_LOCK_CYCLES 100
`define QPAC_REG_STATUS 4'h0
`define QPAC_REG_MASK 4'h1
`define QPAC_REG_CONTROL 4'h2
`define QPAC_REG_CONFIG 4'h3
`define QPAC_REG_REFMODE 4'h4
`define QPAC_REG_OVRCOUNT 4'h5
`define QPAC_REF_EXTERNAL 2'h0
`define QPAC_REF_INT_HALF 2'h1
`define QPAC_REF_PROGRAM 2'h2
`define QPAC_REF_INT_ONE 2'h3
`define QPAC_ST_OVR_BIT 0
`define QPAC_ST_LOCK_BIT 1
`define QPAC_ST_CFG_BIT 2
`endif

// ### design/qpac_sync2.v
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module qpac_sync2 #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset_n,
	// Asynchronous input and synchronised output
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] stable_q;

	// First flop feeds only the second
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_q <= {WIDTH{1'b0}};
			stable_q <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q <= asyncIn;
			stable_q <= meta_q;
		end
	end

	assign syncOut = stable_q;
endmodule
`default_nettype wire

// ### design/qpac_channel.v
// One converter channel: stage decisions, correction, range clamp
`timescale 1ns/1ps
`default_nettype none
`include "qpac_consts.vh"
module qpac_channel #(
	parameter STAGES = `QPAC_STAGES,
	parameter FLASH_BITS = `QPAC_FLASH_BITS
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset_n,
	// Sample in: two-bit codes per stage, flash code
	input wire sampleValid,
	input wire [2*STAGES-1:0] stageCodes,
	input wire [FLASH_BITS-1:0] flashCode,
	input wire overHigh,
	input wire overLow,
	// Corrected word out
	output wire [STAGES+FLASH_BITS-2:0] wordOut,
	output wire overOut,
	output wire validOut
);
	localparam W = STAGES + FLASH_BITS - 1;

	// Stage k holds the codes of the sample it has reached
	reg [2*STAGES-1:0] codes_q [0:STAGES-2];
	reg [STAGES-1:0] vld_q;
	reg [STAGES-1:0] ovh_q;
	reg [STAGES-1:0] ovl_q;
	reg [FLASH_BITS-1:0] flash_q [0:STAGES-2];
	reg [W-1:0] word_q;
	reg over_q;
	reg valid_q;
	reg [W+1:0] sum;
	integer k;
	integer j;

	// Overlapping sum: each 1.5-bit code shifts one bit per stage [R4]
	// Codes are read at the depth of the valid bit, so a short sample
	// period cannot pair a word with a neighbouring sample's codes
	always @*
	begin
		sum = {{(W+2-FLASH_BITS){1'b0}}, flash_q[STAGES-2]};
		for (j = 0; j < STAGES; j = j + 1)
			sum = sum + ({{W{1'b0}}, codes_q[STAGES-2][2*j +: 2]}
				<< (STAGES - 1 - j + FLASH_BITS - 1));
	end

	// A new sample enters stage 0 each clock while older ones move on [R5]
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (k = 0; k < STAGES - 1; k = k + 1)
			begin
				codes_q[k] <= {2*STAGES{1'b0}};
				flash_q[k] <= {FLASH_BITS{1'b0}};
			end
			vld_q <= {STAGES{1'b0}};
			ovh_q <= {STAGES{1'b0}};
			ovl_q <= {STAGES{1'b0}};
			word_q <= {W{1'b0}};
			over_q <= 1'b0;
			valid_q <= 1'b0;
		end
		else
		begin
			codes_q[0] <= stageCodes; // [R2]
			flash_q[0] <= flashCode;
			for (k = 1; k < STAGES - 1; k = k + 1)
			begin
				codes_q[k] <= codes_q[k-1];
				flash_q[k] <= flash_q[k-1];
			end
			vld_q <= {vld_q[STAGES-2:0], sampleValid};
			ovh_q <= {ovh_q[STAGES-2:0], overHigh};
			ovl_q <= {ovl_q[STAGES-2:0], overLow};
			// Merge all decisions into one word, clamp out of range [R3]
			valid_q <= vld_q[STAGES-2];
			if (ovh_q[STAGES-2] || (sum[W+1:W] != 2'b00 && !ovl_q[STAGES-2]))
			begin
				word_q <= {W{1'b1}}; // [R16]
				over_q <= 1'b1;
			end
			else if (ovl_q[STAGES-2])
			begin
				word_q <= {W{1'b0}}; // [R16]
				over_q <= 1'b1;
			end
			else
			begin
				word_q <= sum[W-1:0];
				over_q <= 1'b0;
			end
		end
	end

	assign wordOut = word_q;
	assign overOut = over_q;
	assign validOut = valid_q;
endmodule
`default_nettype wire

// ### design/qpac_core.v
// Top of the quad pipeline converter digital core control
// How it works
// R1 - Capture one sample per rising clock edge
// R2 - Six 1.5-bit stages then 3-bit flash
// R3 - Correction merges stage decisions into 8 bits
// R4 - One redundant overlap bit per early stage
// R5 - New sample each clock, one word out
// R6 - Power-down puts output drivers high-impedance
// R7 - Stabilizer keeps sampling edge, regenerates other (here only reported; no edge is regenerated)
// R8 - Stabilizer-enable low bypasses the stabilizer
// R9 - About 100 cycles to relock after rate change
// R10 - Shared-reference input high selects shared references
// R11 - Sense level decodes into four reference modes
// R12 - Format high twos complement, low offset binary
// R13 - Word appears six clocks after capture
// R14 - Format select defaults low when unconnected
// R15 - Stabilizer-enable high enables, low disables
// R16 - Overrange flags high and clamps word
// R17 - Twos complement inverts offset-binary MSB
// R18 - Format applied as each word leaves correction
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "qpac_consts.vh"
module qpac_core #(
	parameter CHANNELS = `QPAC_CHANNELS,
	parameter STAGES = `QPAC_STAGES,
	parameter FLASH_BITS = `QPAC_FLASH_BITS,
	parameter LOCK_CYCLES = `QPAC_DLL_LOCK_CYCLES,
	parameter RATE_TOL = 2
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset_n,
	// Sample clock from the pin, sampled on ref_clk
	input wire sampleClkIn,
	// Per-channel decisions, held stable for the sample clock period
	input wire [CHANNELS*2*STAGES-1:0] stageCodesIn,
	input wire [CHANNELS*FLASH_BITS-1:0] flashCodesIn,
	input wire [CHANNELS-1:0] overHighIn,
	input wire [CHANNELS-1:0] overLowIn,
	// Straps
	input wire format_select_in,
	input wire stabilizer_enable_in,
	input wire power_down_in,
	input wire sharedRefIn,
	input wire [1:0] senseLevelIn,
	// Register port
	input wire [3:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWrite,
	input wire regRead,
	output wire [31:0] regRdata,
	// Data outputs
	output wire [CHANNELS*(STAGES+FLASH_BITS-1)-1:0] dataOut,
	output wire [CHANNELS*(STAGES+FLASH_BITS-1)-1:0] dataOe,
	output wire [CHANNELS-1:0] overrangeOut,
	output wire [CHANNELS-1:0] overrangeOe,
	output wire wordValid,
	// Status outputs
	output wire clockLocked,
	output wire stabilizerActive,
	output wire sharedRefMode,
	output wire [1:0] refMode,
	output wire irq
);
	localparam W = STAGES + FLASH_BITS - 1;
	// Period counter saturates, so a stopped clock reads as a rate change
	localparam CW = 8;

	// Synchronised pin levels and channel outputs
	wire sClk;
	wire sFmt;
	wire sStab;
	wire sPd;
	wire sShared;
	wire [1:0] sSense;
	wire [CHANNELS-1:0] chValid;
	wire [CHANNELS*W-1:0] chWord;
	wire [CHANNELS-1:0] chOver;

	// Lock tracker, output and register state
	reg sClkPrev_q;
	reg [CW-1:0] periodCnt_q;
	reg [CW-1:0] lastPeriod_q;
	reg [7:0] lockCnt_q;
	reg locked_q;
	reg [CHANNELS*W-1:0] data_q;
	reg [CHANNELS-1:0] over_q;
	reg wvalid_q;
	reg [2:0] status_q;
	reg [2:0] mask_q;
	reg [1:0] control_q;
	reg [31:0] rdata_q;
	reg [15:0] ovrCount_q;
	reg cfgPrev_q;
	reg lockPrev_q;
	reg [31:0] rdata_d;
	// Strobes and decoded controls
	wire samplePulse;
	wire rateChange;
	wire anyOver;
	wire cfgWord;
	wire forcePd;
	wire forceTwos;
	integer i;

	// Reference-mode decode from sense comparator level
	function [1:0] qpac_ref_decode;
		input [1:0] lvl;
		begin
			case (lvl)
				2'b11: qpac_ref_decode = `QPAC_REF_EXTERNAL;
				2'b10: qpac_ref_decode = `QPAC_REF_INT_HALF;
				2'b01: qpac_ref_decode = `QPAC_REF_PROGRAM;
				default: qpac_ref_decode = `QPAC_REF_INT_ONE;
			endcase
		end
	endfunction

	// Pins are asynchronous, so each passes two flops
	qpac_sync2 #(
		.WIDTH(7)
	) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn({sampleClkIn, format_select_in, stabilizer_enable_in,
			power_down_in, sharedRefIn, senseLevelIn}),
		.syncOut({sClk, sFmt, sStab, sPd, sShared, sSense})
	);

	// Rising edge only; falling edge starts nothing [R1]
	assign samplePulse = sClk && !sClkPrev_q;

	// Period tracking stands in for the lock loop; rate change drops lock
	assign rateChange = samplePulse && locked_q
		&& ((periodCnt_q > lastPeriod_q + RATE_TOL[CW-1:0])
		|| (periodCnt_q + RATE_TOL[CW-1:0] < lastPeriod_q));

	// Lock is only reported; words are never held back while unlocked
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sClkPrev_q <= 1'b0;
			periodCnt_q <= {CW{1'b0}};
			lastPeriod_q <= {CW{1'b0}};
			lockCnt_q <= 8'h00;
			locked_q <= 1'b0;
		end
		else
		begin
			sClkPrev_q <= sClk;
			if (samplePulse)
			begin
				periodCnt_q <= {{(CW-1){1'b0}}, 1'b1};
				lastPeriod_q <= periodCnt_q;
			end
			else if (periodCnt_q != {CW{1'b1}})
				periodCnt_q <= periodCnt_q + 1'b1;
			// Bypassed stabilizer needs no lock time [R8] [R15]
			if (!sStab)
			begin
				locked_q <= 1'b1;
				lockCnt_q <= 8'h00;
			end
			else if (rateChange || (!locked_q && lockCnt_q == 8'h00
				&& !sClkPrev_q && lastPeriod_q == {CW{1'b0}}))
			begin
				locked_q <= 1'b0;
				lockCnt_q <= 8'h00;
			end
			else if (!locked_q && samplePulse)
			begin
				// Count sample edges until relocked [R9]
				if (lockCnt_q == LOCK_CYCLES[7:0] - 8'h01)
					locked_q <= 1'b1;
				lockCnt_q <= lockCnt_q + 8'h01;
			end
		end
	end

	// Four channels built alike
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1)
		begin : g_ch
			qpac_channel #(
				.STAGES(STAGES),
				.FLASH_BITS(FLASH_BITS)
			) u_ch (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.sampleValid(samplePulse), // [R1]
				.stageCodes(stageCodesIn[g*2*STAGES +: 2*STAGES]),
				.flashCode(flashCodesIn[g*FLASH_BITS +: FLASH_BITS]),
				.overHigh(overHighIn[g]),
				.overLow(overLowIn[g]),
				.wordOut(chWord[g*W +: W]),
				.overOut(chOver[g]),
				.validOut(chValid[g])
			);
		end
	endgenerate

	// Software may force power-down or twos complement
	assign forcePd = control_q[0];
	assign forceTwos = control_q[1];
	// Pin low (pull-down default) means offset binary [R14]
	assign cfgWord = sFmt || forceTwos;

	// Format applied as the word leaves correction, MSB flip [R12] [R17] [R18]
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			data_q <= {CHANNELS*W{1'b0}};
			over_q <= {CHANNELS{1'b0}};
			wvalid_q <= 1'b0;
		end
		else
		begin
			wvalid_q <= chValid[0]; // Six clocks after capture [R13]
			for (i = 0; i < CHANNELS; i = i + 1)
				if (chValid[i])
				begin
					data_q[i*W +: W] <= {chWord[i*W+W-1] ^ cfgWord,
						chWord[i*W +: W-1]};
					over_q[i] <= chOver[i]; // [R16]
				end
		end
	end

	// Drivers released during power-down [R6]
	assign dataOut = data_q;
	assign dataOe = {CHANNELS*W{!(sPd || forcePd)}};
	assign overrangeOut = over_q;
	assign overrangeOe = {CHANNELS{!(sPd || forcePd)}};
	assign wordValid = wvalid_q;

	// Stabilizer state is only reported; rising edge used, other edge not regenerated [R7] [R15]
	assign stabilizerActive = sStab;
	assign clockLocked = locked_q;
	assign sharedRefMode = sShared; // [R10]
	assign refMode = qpac_ref_decode(sSense); // [R11]

	// Events: overrange word, lock gained, format changed
	assign anyOver = wvalid_q && (|over_q);

	// Status set wins over read-clear; mask, control, counter
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			status_q <= 3'h0;
			mask_q <= 3'h0;
			control_q <= 2'h0;
			ovrCount_q <= 16'h0000;
			cfgPrev_q <= 1'b0;
			lockPrev_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			cfgPrev_q <= cfgWord;
			lockPrev_q <= locked_q;
			rdata_q <= regRead ? rdata_d : 32'h0000_0000;
			if (regRead && regAddr == `QPAC_REG_STATUS)
				status_q <= 3'h0 | {cfgPrev_q != cfgWord,
					locked_q && !lockPrev_q, anyOver};
			else
				status_q <= status_q | {cfgPrev_q != cfgWord,
					locked_q && !lockPrev_q, anyOver};
			if (anyOver && ovrCount_q != 16'hffff)
				ovrCount_q <= ovrCount_q + 16'h0001;
			if (regWrite && regAddr == `QPAC_REG_MASK)
				mask_q <= regWdata[2:0];
			if (regWrite && regAddr == `QPAC_REG_CONTROL)
				control_q <= regWdata[1:0];
			if (regWrite && regAddr == `QPAC_REG_OVRCOUNT)
				ovrCount_q <= 16'h0000;
		end
	end

	// Read mux; unmapped addresses read zero
	always @*
	begin
		case (regAddr)
			`QPAC_REG_STATUS: rdata_d = {29'h0, status_q};
			`QPAC_REG_MASK: rdata_d = {29'h0, mask_q};
			`QPAC_REG_CONTROL: rdata_d = {30'h0, control_q};
			`QPAC_REG_CONFIG: rdata_d = {27'h0, sPd, sShared, sStab,
				locked_q, cfgWord};
			`QPAC_REG_REFMODE: rdata_d = {30'h0, refMode};
			`QPAC_REG_OVRCOUNT: rdata_d = {16'h0, ovrCount_q};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// Read data zero outside the answer cycle, so a bus OR stays safe
	assign regRdata = rdata_q;
	assign irq = |(status_q & mask_q);
endmodule
`default_nettype wire

// ### test/qpac_core_assertions.sv
// Port-level checker for the quad converter core
`timescale 1ns/1ps
`default_nettype none
module qpac_core_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Watched inputs
	input wire logic sampleClkIn,
	input wire logic power_down_in,
	input wire logic stabilizer_enable_in,
	input wire logic sharedRefIn,
	input wire logic [1:0] senseLevelIn,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	// Watched outputs
	input wire logic [31:0] regRdata,
	input wire logic [31:0] dataOut,
	input wire logic [31:0] dataOe,
	input wire logic [3:0] overrangeOut,
	input wire logic [3:0] overrangeOe,
	input wire logic wordValid,
	input wire logic clockLocked,
	input wire logic stabilizerActive,
	input wire logic sharedRefMode,
	input wire logic [1:0] refMode,
	input wire logic irq
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Strap levels reach the status outputs after the two-flop sync
	ref_decode_a: assert property ($stable(senseLevelIn)[*3] |-> refMode == ~senseLevelIn)
		else $error("reference mode does not match sense level");
	shared_ref_a: assert property ($stable(sharedRefIn)[*3] |-> sharedRefMode == sharedRefIn)
		else $error("shared reference mode does not follow strap");
	stab_follow_a: assert property ($stable(stabilizer_enable_in)[*3] |-> stabilizerActive == stabilizer_enable_in)
		else $error("stabilizer state does not follow strap");
	lock_bypass_a: assert property ((!stabilizerActive)[*4] |-> clockLocked)
		else $error("bypassed stabilizer not reported locked");
	// Output drivers released while powered down
	pd_hiz_a: assert property (power_down_in[*4] |-> dataOe == 32'h0 && overrangeOe == 4'h0)
		else $error("outputs driven during power-down");
	// One word per captured sample, after the fixed latency
	valid_pulse_a: assert property (wordValid |=> !wordValid)
		else $error("word valid longer than one cycle");
	valid_latency_a: assert property ($rose(sampleClkIn) |-> ##[9:11] wordValid)
		else $error("no word after sample edge");
	clamp_a: assert property (wordValid && overrangeOut[0] |-> dataOut[6:0] == 7'h7F || dataOut[6:0] == 7'h00)
		else $error("overrange word not clamped");
	irq_mask_a: assert property (regWrite && regAddr == 4'h1 && regWdata == 32'h0 |-> ##2 !irq)
		else $error("interrupt high with all sources masked");
	rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
		else $error("read data outside read answer cycle");
endmodule
bind qpac_core qpac_core_chk u_chk (.ref_clk, .reset_n, .sampleClkIn,
	.power_down_in, .stabilizer_enable_in, .sharedRefIn, .senseLevelIn,
	.regAddr, .regWdata, .regWrite, .regRead, .regRdata, .dataOut, .dataOe,
	.overrangeOut, .overrangeOe, .wordValid, .clockLocked,
	.stabilizerActive, .sharedRefMode, .refMode, .irq);
`default_nettype wire

// ### test/qpac_rx_model.sv
// Receiver-side model that captures the parallel words
`timescale 1ns/1ps
`default_nettype none
module qpac_rx_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Lines from the converter core
	input wire logic [31:0] dataOut,
	input wire logic [31:0] dataOe,
	input wire logic [3:0] overrangeOut,
	input wire logic wordValid,
	// Captured words and seen line levels
	output logic [31:0] rxWord,
	output logic [3:0] rxOvr,
	output logic rxStrobe,
	output logic [31:0] pinLevel
);
	// Released lines float: show the inverse of the last word
	assign pinLevel = (dataOut & dataOe) | (~rxWord & ~dataOe);
	// Capture on each valid pulse, strobe the bench a cycle later
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rxWord <= 32'h0;
			rxOvr <= 4'h0;
			rxStrobe <= 1'b0;
		end
		else
		begin
			rxStrobe <= wordValid;
			if (wordValid)
			begin
				rxWord <= pinLevel;
				rxOvr <= overrangeOut;
			end
		end
	end
endmodule
`default_nettype wire

// ### test/test_quad_pipeline_adc_core_control.sv
// Self-checking bench for the quad converter core
`timescale 1ns/1ps
`default_nettype none
module test_quad_pipeline_adc_core_control;
	localparam int LOCKN = 8;
	logic ref_clk, reset_n, sampleClkIn, regWrite, regRead, wordValid, irq;
	logic format_select_in, stabilizer_enable_in, power_down_in, sharedRefIn;
	logic clockLocked, stabilizerActive, sharedRefMode, rxStrobe, fmtNow;
	logic [47:0] stageCodesIn;
	logic [11:0] flashCodesIn;
	logic [3:0] overHighIn, overLowIn, overrangeOut, overrangeOe, rxOvr, regAddr;
	logic [1:0] senseLevelIn, refMode;
	logic [31:0] regWdata, regRdata, dataOut, dataOe, rxWord, pinLevel;
	logic [35:0] expQ[$];
	int n_mismatch = 0, check_count = 0, cyc = 0, seed = 64527;

	qpac_core #(.LOCK_CYCLES(LOCKN)) u_dut (.ref_clk, .reset_n, .sampleClkIn,
		.stageCodesIn, .flashCodesIn, .overHighIn, .overLowIn,
		.format_select_in, .stabilizer_enable_in, .power_down_in, .sharedRefIn,
		.senseLevelIn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
		.dataOut, .dataOe, .overrangeOut, .overrangeOe, .wordValid,
		.clockLocked, .stabilizerActive, .sharedRefMode, .refMode, .irq);
	qpac_rx_model u_rx (.ref_clk, .reset_n, .dataOut, .dataOe, .overrangeOut,
		.wordValid, .rxWord, .rxOvr, .rxStrobe, .pinLevel);

	// 40 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [35:0] exp, got);
		check_count++;
		if (exp !== got)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Cut a hang short
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch++;
			conclude;
		end
	end

	// Register writes and reads, one-cycle strobes
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFF_FFFF);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		// Data stand in the cycle after the strobe; taken at its closing edge
		@(posedge ref_clk);
		chk("read data", exp, regRdata & m);
	endtask

	// Expected word: weighted stage codes plus flash, clamp, format
	function automatic logic [8:0] ew(input logic [11:0] c, input logic [2:0] f,
		input logic oh, ol, fm);
		int s;
		logic [7:0] w;
		s = f;
		for (int k = 0; k < 6; k++)
			s += int'(c[2*k+:2]) << (7 - k);
		w = (oh || (s > 255 && !ol)) ? 8'hFF : (ol ? 8'h00 : s[7:0]);
		w[7] = w[7] ^ fm;
		return {oh || ol || s > 255, w};
	endfunction

	// One sample period; kind 0 random, 1 over high, 2 low, 3/4 boundary
	task automatic smp(input int half, input int kind);
		logic [47:0] sc;
		logic [11:0] fc;
		logic [35:0] x;
		for (int q = 0; q < 48; q += 2)
			sc[q+:2] = kind < 2 ? 2'({$random(seed)} % 3) : 2'(kind > 2);
		fc = kind < 2 ? 12'($random(seed)) : (kind == 3 ? 12'h6DB : 12'h924);
		fc = kind == 2 ? 12'h000 : fc;
		for (int c = 0; c < 4; c++)
			x[c*9+:9] = ew(sc[c*12+:12], fc[c*3+:3], kind == 1 && c == 0,
				kind == 2 && c[0], fmtNow);
		expQ.push_back(x);
		stageCodesIn <= sc;
		flashCodesIn <= fc;
		overHighIn <= {3'h0, kind == 1};
		overLowIn <= kind == 2 ? 4'hA : 4'h0;
		sampleClkIn <= 1'b1;
		repeat (half) @(posedge ref_clk);
		sampleClkIn <= 1'b0;
		repeat (half) @(posedge ref_clk);
	endtask

	// Compare every word the receiver captures
	always @(posedge ref_clk)
		if (rxStrobe)
		begin
			if (expQ.size() == 0)
				chk("spare word", 36'h1, 36'h0);
			else
				chk("word", expQ.pop_front(), {rxOvr[3], rxWord[31:24], rxOvr[2],
					rxWord[23:16], rxOvr[1], rxWord[15:8], rxOvr[0], rxWord[7:0]});
		end

	initial
	begin
		{reset_n, sampleClkIn, stageCodesIn, flashCodesIn, overHighIn} = '0;
		{overLowIn, format_select_in, power_down_in, sharedRefIn} = '0;
		{senseLevelIn, regAddr, regWdata, regWrite, regRead, fmtNow} = '0;
		stabilizer_enable_in = 1'b1;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int k = 0; k < 5; k++)
			smp(4, k);
		repeat (20) smp(4, 0);
		chk("locked", 1, clockLocked);
		repeat (2) smp(6, 0);
		chk("rate change unlock", 0, clockLocked);
		repeat (LOCKN + 2) smp(6, 0);
		chk("relock", 1, clockLocked);
		$display("offset binary and lock test done");
		repeat (14) @(posedge ref_clk);
		format_select_in <= 1'b1;
		fmtNow = 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int k = 0; k < 12; k++)
			smp(4, k < 5 ? k : 0);
		repeat (14) @(posedge ref_clk);
		format_select_in <= 1'b0;
		wr(4'h2, 32'h2);
		repeat (3) smp(4, 0);
		repeat (14) @(posedge ref_clk);
		wr(4'h2, 32'h0);
		fmtNow = 1'b0;
		$display("format test done");
		rd(4'hF, 32'h0);
		wr(4'h3, 32'hFFFF_FFFF);
		rd(4'h3, 32'h4);
		for (int v = 0; v < 4; v++)
		begin
			senseLevelIn <= 2'(v);
			repeat (4) @(posedge ref_clk);
			rd(4'h4, {30'h0, 2'd3 - 2'(v)});
		end
		sharedRefIn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("shared mode", 1, sharedRefMode);
		$display("register and strap test done");
		rd(4'h0, 32'h0, 32'h0);
		wr(4'h1, 32'h1);
		smp(4, 1);
		repeat (14) @(posedge ref_clk);
		chk("irq raised", 1, irq);
		rd(4'h0, 32'h1, 32'h1);
		chk("irq cleared", 0, irq);
		wr(4'h1, 32'h0);
		smp(4, 1);
		repeat (14) @(posedge ref_clk);
		chk("irq masked", 0, irq);
		wr(4'h1, 32'h1);
		chk("irq unmasked", 1, irq);
		rd(4'h0, 32'h1, 32'h1);
		wr(4'h1, 32'h0);
		wr(4'h5, 32'h0);
		smp(4, 1);
		repeat (14) @(posedge ref_clk);
		rd(4'h5, 32'h1);
		$display("interrupt test done");
		power_down_in <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk("oe in power-down", 0, dataOe);
		chk("ovr oe in power-down", 0, overrangeOe);
		chk("floating lines", {4'h0, ~rxWord}, pinLevel);
		power_down_in <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk("oe after power-down", 32'hFFFF_FFFF, dataOe);
		wr(4'h2, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk("oe forced off", 0, dataOe);
		wr(4'h2, 32'h0);
		chk("unlocked before bypass", 0, clockLocked);
		stabilizer_enable_in <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("stabilizer off", 0, stabilizerActive);
		chk("bypass locked", 1, clockLocked);
		repeat (2) smp(4, 0);
		repeat (14) @(posedge ref_clk);
		chk("words left", 0, expQ.size());
		$display("power-down and bypass test done");
		conclude;
	end
endmodule
`default_nettype wire
